// [pkg/bdc_pkg.sv]
// constants, register layouts and carriers of the bridge driver control registers
package bdc_pkg;

  // serial frame layout
  localparam int FRAME_W = 16;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int FRAME_RW_BIT = 15;
  localparam int FRAME_ADDR_MSB = 14;
  localparam int FRAME_ADDR_LSB = 9;
  localparam int FRAME_READ_LOAD_COUNT = 8;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CHIP_CONTROL = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_BRIDGE_CONTROL = 6'h05;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_SIDE_GATE_CURRENT = 6'h06;

  // reset values
  localparam logic [DATA_W-1:0] RESET_CHIP_CONTROL = 8'h06;
  localparam logic [DATA_W-1:0] RESET_BRIDGE_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] RESET_HIGH_SIDE_GATE_CURRENT = 8'hff;

  // write guard codes
  localparam logic [2:0] GUARD_UNLOCK = 3'h3;
  localparam logic [2:0] GUARD_LOCK = 3'h6;

  // status byte returned in the first half of every frame
  localparam int STATUS_FAULT_BIT = 5;

  typedef enum logic [1:0] {
    SCHEME_HALF_BRIDGE = 2'h0,
    SCHEME_PHASE_ENABLE = 2'h1,
    SCHEME_PWM = 2'h2,
    SCHEME_SPLIT_SOLENOID = 2'h3
  } bdc_scheme_t;

  typedef struct packed {
    logic driver_enable;
    logic spread_clock_disable;
    logic input1_source_select;
    logic input2_source_select;
    logic [2:0] write_guard;
    logic fault_clear_strobe;
  } bdc_chip_control_t;

  typedef struct packed {
    logic gate_handshake_disable;
    bdc_scheme_t bridge_input_scheme;
    logic freewheel_side;
    logic soft_input1;
    logic soft_input2;
    logic soft_float1;
    logic soft_float2;
  } bdc_bridge_control_t;

  typedef struct packed {
    logic [3:0] hs_source_current_code;
    logic [3:0] hs_sink_current_code;
  } bdc_gate_current_t;

  // settings handed to the analog gate stages and clock generator
  typedef struct packed {
    logic driver_enable;
    logic spread_clock_disable;
    logic gate_handshake_disable;
    bdc_scheme_t bridge_input_scheme;
    logic freewheel_side;
    logic [3:0] hs_source_current_code;
    logic [3:0] hs_sink_current_code;
  } bdc_cfg_t;

  // resolved bridge inputs
  typedef struct packed {
    logic bridge_input1;
    logic bridge_input2;
    logic float1;
    logic float2;
    logic gate_pulldown;
  } bdc_bridge_t;

endpackage

// [rtl/bdc_ctrl_regs.sv]
// serial-access control registers of the bridge gate driver
//
// Contract
// RULE1 - driver enable low ignores inputs, pulldowns on
// RULE2 - spread clock disable bit turns modulation off
// RULE3 - input1 select picks pin or soft input1
// RULE4 - input2 select picks pin or soft input2
// RULE5 - guard code 011b unlocks control registers
// RULE6 - guard code 110b locks all but guard
// RULE7 - other guard codes keep lock; resets unlocked
// RULE8 - fault clear strobe clears faults, self-returns
// RULE9 - handshake disable bit selects dead-time timing
// RULE10 - scheme field selects bridge input interpretation
// RULE11 - freewheel side bit picks low or high
// RULE12 - soft input1 used only when selected
// RULE13 - soft input2 used only when selected
// RULE14 - half-bridge 1 floats on soft or pin
// RULE15 - half-bridge 2 floats on soft or pin
// RULE16 - high-side source current code, 16 steps
// RULE17 - high-side sink current code, 16 steps
// RULE18 - fault status bit mirrors fault output pin
// RULE19 - lock flag resets unlocked, guard codes only
`timescale 1ns/1ps
`default_nettype none

module bdc_ctrl_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial port
  input wire logic spi_clk,
  input wire logic spi_select_n,
  input wire logic spi_data_in,
  output logic spi_data_out,
  output logic spi_data_out_oe_n,
  // bridge pins
  input wire logic bridge_input1_pin,
  input wire logic bridge_input2_pin,
  input wire logic float1_pin_low,
  input wire logic float2_pin_low,
  // fault latches
  input wire logic fault_active,
  output logic fault_clear,
  output logic fault_out_pin_low,
  // settings and resolved bridge inputs
  output bdc_pkg::bdc_cfg_t cfg,
  output bdc_pkg::bdc_bridge_t bridge
);

  typedef enum logic {
    BDC_IDLE,
    BDC_SHIFT
  } bdc_frame_state_t;

  // register storage
  bdc_pkg::bdc_chip_control_t chip_control;
  bdc_pkg::bdc_chip_control_t next_chip_control;
  bdc_pkg::bdc_bridge_control_t bridge_control;
  bdc_pkg::bdc_bridge_control_t next_bridge_control;
  bdc_pkg::bdc_gate_current_t high_side_gate_current;
  bdc_pkg::bdc_gate_current_t next_high_side_gate_current;
  logic locked;
  logic next_locked;
  logic next_fault_clear;
  logic next_fault_out_pin_low;
  bdc_pkg::bdc_cfg_t next_cfg;

  // serial frame state
  bdc_frame_state_t frame_state;
  bdc_frame_state_t next_frame_state;
  logic spi_clk_q;
  logic [bdc_pkg::FRAME_W-1:0] rx_shift;
  logic [bdc_pkg::FRAME_W-1:0] next_rx_shift;
  logic [4:0] bit_count;
  logic [4:0] next_bit_count;
  logic [bdc_pkg::DATA_W-1:0] read_data;
  logic [bdc_pkg::DATA_W-1:0] next_read_data;
  logic next_spi_data_out;
  logic next_spi_data_out_oe_n;

  logic clk_rise;
  logic clk_fall;
  logic frame_end;
  logic write_commit;
  logic [bdc_pkg::ADDR_W-1:0] frame_addr;
  logic [bdc_pkg::DATA_W-1:0] frame_data;
  logic [bdc_pkg::FRAME_W-1:0] tx_word;
  logic [bdc_pkg::DATA_W-1:0] status_byte;
  logic [3:0] tx_index;

  // register readback by offset, zero for unmapped offsets
  function automatic logic [bdc_pkg::DATA_W-1:0] read_reg(
    input logic [bdc_pkg::ADDR_W-1:0] addr,
    input bdc_pkg::bdc_chip_control_t cc,
    input bdc_pkg::bdc_bridge_control_t bc,
    input bdc_pkg::bdc_gate_current_t gc
  );
    logic [bdc_pkg::DATA_W-1:0] value;
    value = 8'h00;
    unique case (addr)
      bdc_pkg::ADDR_CHIP_CONTROL: value = cc;
      bdc_pkg::ADDR_BRIDGE_CONTROL: value = bc;
      bdc_pkg::ADDR_HIGH_SIDE_GATE_CURRENT: value = gc;
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  // ---- serial frame engine ----
  always_comb
  begin
    clk_rise = spi_clk & ~spi_clk_q;
    clk_fall = ~spi_clk & spi_clk_q;
    frame_addr = rx_shift[bdc_pkg::FRAME_ADDR_MSB:bdc_pkg::FRAME_ADDR_LSB];
    frame_data = rx_shift[bdc_pkg::DATA_W-1:0];
    frame_end = (frame_state == BDC_SHIFT) & spi_select_n;
    // only frames of at least sixteen bits write; clocks past the sixteenth bit are ignored
    write_commit = frame_end & (bit_count == bdc_pkg::FRAME_BITS)
                   & ~rx_shift[bdc_pkg::FRAME_RW_BIT];
    status_byte = 8'h00;
    status_byte[bdc_pkg::STATUS_FAULT_BIT] = ~fault_out_pin_low; // RULE18
    tx_word = {status_byte, read_data};
    tx_index = 4'hf - bit_count[3:0];

    next_frame_state = frame_state;
    next_rx_shift = rx_shift;
    next_bit_count = bit_count;
    next_read_data = read_data;
    next_spi_data_out = spi_data_out;
    next_spi_data_out_oe_n = spi_data_out_oe_n;

    unique case (frame_state)
      BDC_IDLE:
      begin
        next_spi_data_out_oe_n = 1'b1;
        next_spi_data_out = 1'b0;
        if (!spi_select_n)
        begin
          next_frame_state = BDC_SHIFT;
          next_bit_count = 5'h00;
          next_read_data = 8'h00;
          next_spi_data_out_oe_n = 1'b0;
          next_spi_data_out = status_byte[bdc_pkg::DATA_W-1];
        end
      end
      BDC_SHIFT:
      begin
        if (spi_select_n)
        begin
          next_frame_state = BDC_IDLE;
          next_spi_data_out_oe_n = 1'b1;
          next_spi_data_out = 1'b0;
        end
        else
        begin
          if (clk_rise && bit_count != bdc_pkg::FRAME_BITS)
          begin
            next_rx_shift = {rx_shift[bdc_pkg::FRAME_W-2:0], spi_data_in};
            next_bit_count = bit_count + 5'h01;
            // address is complete after the eighth bit, sitting one above the lsb
            if (bit_count == 5'(bdc_pkg::FRAME_READ_LOAD_COUNT - 1))
              next_read_data = read_reg(
                next_rx_shift[bdc_pkg::FRAME_ADDR_MSB-bdc_pkg::FRAME_READ_LOAD_COUNT:
                              bdc_pkg::FRAME_ADDR_LSB-bdc_pkg::FRAME_READ_LOAD_COUNT],
                                        chip_control, bridge_control,
                                        high_side_gate_current);
          end
          if (clk_fall && bit_count != bdc_pkg::FRAME_BITS)
            next_spi_data_out = tx_word[tx_index];
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      frame_state <= BDC_IDLE;
      spi_clk_q <= 1'b0;
      rx_shift <= 16'h0000;
      bit_count <= 5'h00;
      read_data <= 8'h00;
      spi_data_out <= 1'b0;
      spi_data_out_oe_n <= 1'b1;
    end
    else
    begin
      frame_state <= next_frame_state;
      spi_clk_q <= spi_clk;
      rx_shift <= next_rx_shift;
      bit_count <= next_bit_count;
      read_data <= next_read_data;
      spi_data_out <= next_spi_data_out;
      spi_data_out_oe_n <= next_spi_data_out_oe_n;
    end
  end

  // ---- control registers ----
  always_comb
  begin
    next_chip_control = chip_control;
    next_bridge_control = bridge_control;
    next_high_side_gate_current = high_side_gate_current;
    next_locked = locked;
    // strobe returns to zero on the same edge that sends out the clear pulse
    next_chip_control.fault_clear_strobe = 1'b0; // RULE8
    next_fault_clear = chip_control.fault_clear_strobe; // RULE8

    if (write_commit && frame_addr == bdc_pkg::ADDR_CHIP_CONTROL)
    begin
      // guard field always writable, lock flag follows only the two codes
      next_chip_control.write_guard = frame_data[3:1];
      if (frame_data[3:1] == bdc_pkg::GUARD_UNLOCK)
        next_locked = 1'b0; // RULE5 RULE19
      else if (frame_data[3:1] == bdc_pkg::GUARD_LOCK)
        next_locked = 1'b1; // RULE6 RULE19
      else
        next_locked = locked; // RULE7
      if (!locked)
      begin
        next_chip_control.driver_enable = frame_data[7];
        next_chip_control.spread_clock_disable = frame_data[6];
        next_chip_control.input1_source_select = frame_data[5];
        next_chip_control.input2_source_select = frame_data[4];
        // a new request wins over the self-return
        next_chip_control.fault_clear_strobe = frame_data[0]; // RULE8
      end
    end

    if (write_commit && !locked) // RULE6
    begin
      if (frame_addr == bdc_pkg::ADDR_BRIDGE_CONTROL)
        next_bridge_control = frame_data;
      if (frame_addr == bdc_pkg::ADDR_HIGH_SIDE_GATE_CURRENT)
        next_high_side_gate_current = frame_data; // RULE16 RULE17
    end

    next_fault_out_pin_low = ~fault_active;

    next_cfg.driver_enable = chip_control.driver_enable; // RULE1
    next_cfg.spread_clock_disable = chip_control.spread_clock_disable; // RULE2
    next_cfg.gate_handshake_disable = bridge_control.gate_handshake_disable; // RULE9
    next_cfg.bridge_input_scheme = bridge_control.bridge_input_scheme; // RULE10
    next_cfg.freewheel_side = bridge_control.freewheel_side; // RULE11
    next_cfg.hs_source_current_code = high_side_gate_current.hs_source_current_code; // RULE16
    next_cfg.hs_sink_current_code = high_side_gate_current.hs_sink_current_code; // RULE17
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      chip_control <= bdc_pkg::RESET_CHIP_CONTROL; // RULE7
      bridge_control <= bdc_pkg::RESET_BRIDGE_CONTROL;
      high_side_gate_current <= bdc_pkg::RESET_HIGH_SIDE_GATE_CURRENT;
      locked <= 1'b0; // RULE19
      fault_clear <= 1'b0;
      fault_out_pin_low <= 1'b1;
      cfg <= '0;
    end
    else
    begin
      chip_control <= next_chip_control;
      bridge_control <= next_bridge_control;
      high_side_gate_current <= next_high_side_gate_current;
      locked <= next_locked;
      fault_clear <= next_fault_clear;
      fault_out_pin_low <= next_fault_out_pin_low; // RULE18
      cfg <= next_cfg;
    end
  end

  // ---- bridge input resolution ----
  bdc_gate_mux u_gate_mux (
    .ref_clk(ref_clk),
    .rst(rst),
    .chip(chip_control),
    .bridge_ctl(bridge_control),
    .bridge_input1_pin(bridge_input1_pin),
    .bridge_input2_pin(bridge_input2_pin),
    .float1_pin_low(float1_pin_low),
    .float2_pin_low(float2_pin_low),
    .bridge(bridge)
  );

endmodule // bdc_ctrl_regs

`default_nettype wire

// [rtl/bdc_gate_mux.sv]
// input source selection and float resolution for the two half-bridges
`timescale 1ns/1ps
`default_nettype none

module bdc_gate_mux (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register settings
  input wire bdc_pkg::bdc_chip_control_t chip,
  input wire bdc_pkg::bdc_bridge_control_t bridge_ctl,
  // pins
  input wire logic bridge_input1_pin,
  input wire logic bridge_input2_pin,
  input wire logic float1_pin_low,
  input wire logic float2_pin_low,
  // resolved outputs
  output var bdc_pkg::bdc_bridge_t bridge
);

  bdc_pkg::bdc_bridge_t next_bridge;
  logic in1;
  logic in2;
  logic half_mode;

  always_comb
  begin
    in1 = chip.input1_source_select ? bridge_ctl.soft_input1 : bridge_input1_pin; // RULE3 RULE12
    in2 = chip.input2_source_select ? bridge_ctl.soft_input2 : bridge_input2_pin; // RULE4 RULE13
    half_mode = (bridge_ctl.bridge_input_scheme == bdc_pkg::SCHEME_HALF_BRIDGE);
    next_bridge.float1 = half_mode & (bridge_ctl.soft_float1 | ~float1_pin_low); // RULE14
    next_bridge.float2 = half_mode & (bridge_ctl.soft_float2 | ~float2_pin_low); // RULE15
    next_bridge.bridge_input1 = in1 & ~next_bridge.float1;
    next_bridge.bridge_input2 = in2 & ~next_bridge.float2;
    next_bridge.gate_pulldown = 1'b0;
    if (!chip.driver_enable)
    begin
      // inputs ignored, passive pulldowns on
      next_bridge.bridge_input1 = 1'b0; // RULE1
      next_bridge.bridge_input2 = 1'b0;
      next_bridge.gate_pulldown = 1'b1; // RULE1
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      bridge <= '{bridge_input1: 1'b0, bridge_input2: 1'b0, float1: 1'b0, float2: 1'b0,
                  gate_pulldown: 1'b1};
    else
      bridge <= next_bridge;
  end

endmodule // bdc_gate_mux

`default_nettype wire

// [verification/bdc_ctrl_regs_asserts.sv]
// port assertions for the bridge driver control registers
`timescale 1ns/1ps
`default_nettype none
module bdc_ctrl_regs_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // watched ports
  input wire logic spi_select_n,
  input wire logic spi_data_out_oe_n,
  input wire logic float1_pin_low,
  input wire logic float2_pin_low,
  input wire logic fault_active,
  input wire logic fault_clear,
  input wire logic fault_out_pin_low,
  input wire bdc_pkg::bdc_cfg_t cfg,
  input wire bdc_pkg::bdc_bridge_t bridge
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_start;
    spi_select_n ##1 !spi_select_n;
  endsequence
  sequence s_end;
    !spi_select_n ##1 spi_select_n;
  endsequence
  a_frame_drive: assert property (s_start |=> !spi_data_out_oe_n)
    else $error("data out not enabled at frame start");
  a_frame_release: assert property (s_end |=> spi_data_out_oe_n)
    else $error("data out still enabled after frame");
  a_cfg_after_frame: assert property (
    !$stable(cfg) |-> $past(spi_select_n) && $past(spi_select_n, 2))
    else $error("settings changed outside frame end");
  a_fault_mirror: assert property (fault_active |=> !fault_out_pin_low)
    else $error("fault pin not asserted");
  a_clear_one_pulse: assert property (
    fault_clear |-> !$past(spi_select_n, 3) && $past(spi_select_n, 2) ##1 !fault_clear)
    else $error("clear pulse wrong");
  a_off_pulldown: assert property (
    !cfg.driver_enable |->
      bridge.gate_pulldown && !bridge.bridge_input1 && !bridge.bridge_input2)
    else $error("disabled driver not pulled down");
  a_float1_low: assert property (
    bridge.float1 |->
      !bridge.bridge_input1 && cfg.bridge_input_scheme == bdc_pkg::SCHEME_HALF_BRIDGE)
    else $error("float1 wrong");
  a_pin_float1: assert property (
    cfg.driver_enable && cfg.bridge_input_scheme == bdc_pkg::SCHEME_HALF_BRIDGE
      && !$past(float1_pin_low) |-> bridge.float1)
    else $error("float1 pin ignored");
  a_pin_float2: assert property (
    cfg.driver_enable && cfg.bridge_input_scheme == bdc_pkg::SCHEME_HALF_BRIDGE
      && !$past(float2_pin_low) |-> bridge.float2 && !bridge.bridge_input2)
    else $error("float2 pin ignored");
endmodule // bdc_ctrl_regs_asserts
bind bdc_ctrl_regs bdc_ctrl_regs_asserts u_bdc_ctrl_regs_asserts (.ref_clk, .rst, .spi_select_n,
  .spi_data_out_oe_n, .float1_pin_low, .float2_pin_low, .fault_active, .fault_clear,
  .fault_out_pin_low, .cfg, .bridge);
`default_nettype wire

// [verification/bdc_spi_host.sv]
// serial host model issuing 16-bit frames
`timescale 1ns/1ps
`default_nettype none
module bdc_spi_host (
  // clock
  input wire logic ref_clk,
  // serial lines
  output var logic spi_clk,
  output var logic spi_select_n,
  output var logic spi_data_in,
  input wire logic miso
);
  initial
  begin
    spi_clk = 1'b0;
    spi_select_n = 1'b1;
    spi_data_in = 1'b0;
  end
  // clock stands still between frames, data idles at the inverse of its last bit
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(negedge ref_clk);
    spi_select_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_data_in = w[i];
      repeat (3) @(negedge ref_clk);
      r[i] = miso;
      spi_clk = 1'b1;
      repeat (3) @(negedge ref_clk);
      spi_clk = 1'b0;
    end
    spi_data_in = ~w[0];
    repeat (2) @(negedge ref_clk);
    spi_select_n = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule // bdc_spi_host
`default_nettype wire

// [verification/tb_bdc_ctrl_regs.sv]
// self-checking bench for the bridge driver control registers
`timescale 1ns/1ps
`default_nettype none
module tb_bdc_ctrl_regs;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pin1 = 1'b0;
  logic pin2 = 1'b0;
  logic float1_pin_low = 1'b1;
  logic float2_pin_low = 1'b1;
  logic fault_active = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  int n_clr = 0;
  wire logic spi_clk;
  wire logic spi_select_n;
  wire logic spi_data_in;
  logic spi_data_out;
  logic spi_data_out_oe_n;
  logic fault_clear;
  logic fault_out_pin_low;
  bdc_pkg::bdc_cfg_t cfg;
  bdc_pkg::bdc_bridge_t bridge;
  wire logic miso = spi_data_out_oe_n ? 1'bz : spi_data_out;
  always #20 ref_clk = ~ref_clk;
  // fault latches drop when cleared
  always @(posedge ref_clk)
    if (fault_clear === 1'b1)
    begin
      n_clr++;
      fault_active <= 1'b0;
    end
  bdc_ctrl_regs u_bdc_ctrl_regs (.ref_clk, .rst, .spi_clk, .spi_select_n, .spi_data_in,
    .spi_data_out, .spi_data_out_oe_n, .bridge_input1_pin(pin1), .bridge_input2_pin(pin2),
    .float1_pin_low, .float2_pin_low, .fault_active, .fault_clear, .fault_out_pin_low,
    .cfg, .bridge);
  bdc_spi_host u_bdc_spi_host (.ref_clk, .spi_clk, .spi_select_n, .spi_data_in, .miso);
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] r;
    u_bdc_spi_host.xfer({1'b0, a, 1'b0, d}, r);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    logic [15:0] r;
    u_bdc_spi_host.xfer({1'b1, a, 9'h000}, r);
    check($sformatf("reg %h", a), r, {2'h0, fault_active, 5'h00, e});
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic t_reset;
    rdc(6'h04, 8'h06);
    rdc(6'h05, 8'h00);
    rdc(6'h06, 8'hff);
    rdc(6'h07, 8'h00);
    check("cfg", 16'(cfg), 16'h00ff);
  endtask
  task automatic t_codes;
    logic [7:0] v[3] = '{8'h0f, 8'hf0, 8'h5a};
    foreach (v[i])
    begin
      wr(6'h06, v[i]);
      rdc(6'h06, v[i]);
      check("codes", 16'({cfg.hs_source_current_code, cfg.hs_sink_current_code}),
        16'(v[i]));
    end
  endtask
  task automatic t_modes;
    logic [1:0] s;
    logic [4:0] got;
    for (int i = 0; i < 4; i++)
    begin
      s = i[1:0];
      wr(6'h04, {1'b0, s[0], 2'h0, 3'h3, 1'b0});
      wr(6'h05, {s[0], s, s[1], 4'h0});
      got = {cfg.spread_clock_disable, cfg.gate_handshake_disable, cfg.bridge_input_scheme,
        cfg.freewheel_side};
      check("modes", 16'(got), 16'({s[0], s[0], s, s[1]}));
    end
  endtask
  task automatic t_mux;
    wr(6'h04, 8'h86);
    wr(6'h05, 8'h40);
    pin1 = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("bridge", 16'(bridge), 16'h0010);
    pin1 = 1'b0;
    pin2 = 1'b1;
    wr(6'h05, 8'h48);
    check("bridge", 16'(bridge), 16'h0008);
    wr(6'h04, 8'hb6);
    check("bridge", 16'(bridge), 16'h0010);
    wr(6'h04, 8'h36);
    check("bridge", 16'(bridge), 16'h0001);
  endtask
  task automatic t_float;
    pin1 = 1'b1;
    wr(6'h04, 8'h86);
    wr(6'h05, 8'h02);
    check("bridge", 16'(bridge), 16'h000c);
    float2_pin_low = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("bridge", 16'(bridge), 16'h0006);
    float2_pin_low = 1'b1;
    wr(6'h05, 8'h21);
    check("bridge", 16'(bridge), 16'h0018);
  endtask
  task automatic t_lock;
    wr(6'h04, 8'h0c);
    wr(6'h06, 8'h12);
    rdc(6'h06, 8'h5a);
    wr(6'h04, 8'h8a);
    rdc(6'h04, 8'h0a);
    wr(6'h06, 8'h12);
    rdc(6'h06, 8'h5a);
    wr(6'h04, 8'h06);
    wr(6'h06, 8'h12);
    rdc(6'h06, 8'h12);
    wr(6'h04, 8'h0c);
    do_reset();
    wr(6'h06, 8'h34);
    rdc(6'h06, 8'h34);
  endtask
  task automatic t_fault;
    fault_active = 1'b1;
    repeat (2) @(negedge ref_clk);
    rdc(6'h05, 8'h00);
    n_clr = 0;
    wr(6'h04, 8'h07);
    check("clear pulses", 16'(n_clr), 16'h0001);
    rdc(6'h04, 8'h06);
  endtask
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
  initial
  begin
    do_reset();
    t_reset();
    t_codes();
    t_modes();
    t_mux();
    t_float();
    t_lock();
    t_fault();
    test_done();
  end
endmodule // tb_bdc_ctrl_regs
`default_nettype wire
